// file: include/light_sensor_consts.svh
`ifndef LIGHT_SENSOR_CONSTS_SVH
`define LIGHT_SENSOR_CONSTS_SVH

// register pointers
`define ADDR_RESULT 8'h00
`define ADDR_CONFIG 8'h01
`define ADDR_LOWER 8'h02
`define ADDR_UPPER 8'h03
`define ADDR_MAKER 8'h7E
`define ADDR_PART 8'h7F

// result field positions
`define EXP_MSB 15
`define EXP_LSB 12
`define MANT_MSB 11
`define MANT_LSB 0

// range codes
`define RANGE_AUTO 4'hC
`define RANGE_TOP 4'hB
`define MANT_FULL 12'hFFF

// configuration layout
`define CFG_RESET 16'hC810
`define CFG_WR_MASK 16'hFE1F
`define CFG_STATUS_LSB 5
`define CFG_ME_BIT 2
`define CFG_RANGE_MSB 15
`define CFG_RANGE_LSB 12

// threshold reset values
`define LOWER_RESET 16'h0000
`define UPPER_RESET 16'hBFFF

// identity values, arbitrary
`define MAKER_ID 16'h1234
`define PART_ID 16'h5678

// bus codes
`define GC_ADDR 7'h00
`define GC_RESET_CMD 8'h06
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define LAST_PHASE 3'h3

`endif

// file: include/light_sensor_pkg.sv
package light_sensor_pkg;

    // one conversion outcome, exponent over mantissa
    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } conv_s;

    // sampled two-wire bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_in_s;

    // serial target states
    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_addr = 6'h02,
        st_rx = 6'h04,
        st_ack = 6'h08,
        st_tx = 6'h10,
        st_mack = 6'h20
    } link_state_e;

endpackage : light_sensor_pkg

// file: rtl/result_packer.sv
`timescale 1ns/1ps
`include "light_sensor_consts.svh"

module result_packer import light_sensor_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic gc_reset,
    input wire logic conv_valid,
    input wire conv_s conv_data,
    input wire logic [3:0] range_select_code,
    input wire logic exponent_mask_enable,
    output conv_s result
);

    conv_s next_result; // value to be stored
    logic auto_mode; // automatic range choice active

    assign auto_mode = (range_select_code >= `RANGE_AUTO);

    // form the reported word for each finished conversion
    always_comb begin
        next_result = result;
        if (gc_reset) begin
            next_result = '0;
        end else if (conv_valid) begin
            // auto reports the chosen range, manual the programmed one
            next_result.exponent = auto_mode ? conv_data.exponent : range_select_code;
            next_result.mantissa = conv_data.mantissa;
            // no undefined weights ever reach the register
            if (next_result.exponent > `RANGE_TOP) begin
                next_result.exponent = `RANGE_TOP;
                next_result.mantissa = `MANT_FULL;
            end
            // mask hides the exponent in manual range only
            if (exponent_mask_enable && !auto_mode) begin
                next_result.exponent = 4'h0;
            end
        end
    end

    // register; clears to all zeros
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

    a_exp_defined: assert property (@(posedge core_clk) disable iff (sys_rst)
        result.exponent <= `RANGE_TOP) else $error("undefined exponent stored");
    a_mask_zero_exp: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv_valid && !gc_reset && exponent_mask_enable && range_select_code < `RANGE_AUTO
        |=> result.exponent == 4'h0) else $error("masked exponent not zero");
    a_auto_exp: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv_valid && !gc_reset && auto_mode && conv_data.exponent <= `RANGE_TOP
        |=> result == $past(conv_data)) else $error("auto range not reported");
    a_latest_mant: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv_valid && !gc_reset && !auto_mode
        |=> result.mantissa == $past(conv_data.mantissa)) else $error("mantissa not latest");
    a_reset_zero: assert property (@(posedge core_clk)
        sys_rst |=> result == '0) else $error("result not zero after reset");
    c_auto_conv: cover property (@(posedge core_clk) disable iff (sys_rst) conv_valid && auto_mode);
    c_masked_conv: cover property (@(posedge core_clk) disable iff (sys_rst)
        conv_valid && exponent_mask_enable && !auto_mode);

endmodule : result_packer

// file: rtl/light_sensor_regs.sv
`timescale 1ns/1ps
`include "light_sensor_consts.svh"

//
// Behaviour
// - all registers sixteen bits, moved whole
// - pointers 00h-03h select result, config, thresholds
// - read-only identity words at 7Eh, 7Fh
// - result read-only, holds latest conversion
// - exponent bits 15:12, mantissa bits 11:0
// - result reads zero after reset
// - codes 0-11 weigh 0.01 lux times 2^e
// - mask zeroes exponent in manual range
// - code 1100b selects automatic range reporting
// - pointer byte first, data MSB first
// - pointer kept until next write or general-call reset
module light_sensor_regs import light_sensor_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire bus_in_s bus_in,
    input wire logic [6:0] target_addr,
    output logic sda_out,
    output logic sda_oe,
    input wire logic conv_valid,
    input wire conv_s conv_data,
    input wire logic [3:0] status_bits,
    output logic [15:0] cfg_word,
    output logic cfg_write,
    output logic [15:0] lower_threshold,
    output logic [15:0] upper_threshold,
    output logic gc_reset,
    output conv_s conversion_result
);

    link_state_e state, next_state; // serial target state
    logic scl_q, next_scl_q; // previous clock line
    logic sda_q, next_sda_q; // previous data line
    logic [7:0] rx_sh, next_rx_sh; // receive shifter
    logic [7:0] tx_sh, next_tx_sh; // transmit shifter
    logic [3:0] bit_cnt, next_bit_cnt; // bits in current byte
    logic [2:0] phase, next_phase; // byte index after address
    logic is_read, next_is_read; // read direction
    logic is_gc, next_is_gc; // general call in progress
    logic acked, next_acked; // controller acknowledged
    logic rd_lo, next_rd_lo; // next byte sent is low byte
    logic [7:0] pointer, next_pointer; // register pointer
    logic [7:0] msb_buf, next_msb_buf; // high byte of a write
    logic [15:0] rd_word, next_rd_word; // word snapshot for read
    logic [15:0] operating_configuration, next_cfg; // writable config bits
    logic [15:0] next_lower, next_upper; // threshold next values
    logic next_cfg_write, next_gc_reset; // pulse next values
    logic rise, fall, start_cond, stop_cond; // bus events
    logic [15:0] write_word; // assembled write data

    // all registers answer in sixteen bits; unmapped pointers read zero
    function automatic logic [15:0] reg_read(input logic [7:0] ptr, input logic [15:0] cfgv,
            input logic [3:0] stat, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] res);
        logic [15:0] status_word;
        status_word = {7'h00, stat, 5'h00};
        if (ptr == `ADDR_RESULT) begin
            reg_read = res;
        end else if (ptr == `ADDR_CONFIG) begin
            reg_read = (cfgv & `CFG_WR_MASK) | status_word;
        end else if (ptr == `ADDR_LOWER) begin
            reg_read = lo;
        end else if (ptr == `ADDR_UPPER) begin
            reg_read = hi;
        end else if (ptr == `ADDR_MAKER) begin
            reg_read = `MAKER_ID;
        end else if (ptr == `ADDR_PART) begin
            reg_read = `PART_ID;
        end else begin
            reg_read = 16'h0000;
        end
    endfunction : reg_read

    // bus line events, inputs already synchronous
    assign rise = bus_in.scl && !scl_q;
    assign fall = !bus_in.scl && scl_q;
    assign start_cond = bus_in.scl && scl_q && sda_q && !bus_in.sda;
    assign stop_cond = bus_in.scl && scl_q && !sda_q && bus_in.sda;
    assign write_word = {msb_buf, rx_sh};

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = (state == st_ack) || (state == st_tx && !tx_sh[7]);
    assign cfg_word = operating_configuration;

    // conversion word packing lives in its own module
    result_packer u_packer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .gc_reset(gc_reset),
        .conv_valid(conv_valid),
        .conv_data(conv_data),
        .range_select_code(operating_configuration[`CFG_RANGE_MSB:`CFG_RANGE_LSB]),
        .exponent_mask_enable(operating_configuration[`CFG_ME_BIT]),
        .result(conversion_result)
    );

    // serial target and register writes
    always_comb begin
        next_state = state;
        next_scl_q = bus_in.scl;
        next_sda_q = bus_in.sda;
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_bit_cnt = bit_cnt;
        next_phase = phase;
        next_is_read = is_read;
        next_is_gc = is_gc;
        next_acked = acked;
        next_rd_lo = rd_lo;
        next_pointer = pointer;
        next_msb_buf = msb_buf;
        next_rd_word = rd_word;
        next_cfg = operating_configuration;
        next_lower = lower_threshold;
        next_upper = upper_threshold;
        next_cfg_write = 1'b0;
        next_gc_reset = 1'b0;
        if (start_cond) begin
            // start or repeated start: expect an address byte
            next_state = st_addr;
            next_bit_cnt = 4'h0;
            next_phase = 3'h0;
        end else if (stop_cond) begin
            next_state = st_idle;
        end else begin
            case (state)
                st_addr, st_rx: begin
                    if (rise) begin
                        next_rx_sh = {rx_sh[6:0], bus_in.sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (fall && bit_cnt == `BYTE_BITS) begin
                        next_bit_cnt = 4'h0;
                        next_state = st_ack;
                        if (state == st_addr) begin
                            // own address or general call, else stay silent
                            if (rx_sh[7:1] == target_addr) begin
                                next_is_read = rx_sh[0];
                                next_is_gc = 1'b0;
                            end else if (rx_sh == {`GC_ADDR, 1'b0}) begin
                                next_is_read = 1'b0;
                                next_is_gc = 1'b1;
                            end else begin
                                next_state = st_idle;
                            end
                        end else if (is_gc) begin
                            // reset command puts every register to defaults
                            if (rx_sh == `GC_RESET_CMD) begin
                                next_gc_reset = 1'b1;
                                next_cfg = `CFG_RESET;
                                next_lower = `LOWER_RESET;
                                next_upper = `UPPER_RESET;
                                next_pointer = 8'h00;
                                next_is_gc = 1'b0;
                            end else begin
                                next_state = st_idle;
                            end
                        end else begin
                            if (phase == 3'h0) begin
                                next_pointer = rx_sh;
                            end else if (phase == 3'h1) begin
                                next_msb_buf = rx_sh;
                            end else if (phase == 3'h2) begin
                                // whole word commits on the low byte
                                if (pointer == `ADDR_CONFIG) begin
                                    next_cfg = write_word & `CFG_WR_MASK;
                                    next_cfg_write = 1'b1;
                                end else if (pointer == `ADDR_LOWER) begin
                                    next_lower = write_word;
                                end else if (pointer == `ADDR_UPPER) begin
                                    next_upper = write_word;
                                end
                                // result and identity writes fall through unused
                            end
                            if (phase != `LAST_PHASE) begin
                                next_phase = phase + 3'h1;
                            end
                        end
                    end
                end
                st_ack: begin
                    if (fall) begin
                        if (is_read) begin
                            // snapshot word, high byte first
                            next_rd_word = reg_read(pointer, operating_configuration, status_bits,
                                lower_threshold, upper_threshold, conversion_result);
                            next_tx_sh = next_rd_word[15:8];
                            next_rd_lo = 1'b1;
                            next_state = st_tx;
                        end else begin
                            next_state = st_rx;
                        end
                    end
                end
                st_tx: begin
                    if (fall) begin
                        if (bit_cnt == `LAST_BIT) begin
                            next_bit_cnt = 4'h0;
                            next_state = st_mack;
                        end else begin
                            next_tx_sh = {tx_sh[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                st_mack: begin
                    if (rise) begin
                        next_acked = !bus_in.sda;
                    end else if (fall) begin
                        // ack continues alternating bytes, nack ends
                        if (acked) begin
                            next_tx_sh = rd_lo ? rd_word[7:0] : rd_word[15:8];
                            next_rd_lo = !rd_lo;
                            next_state = st_tx;
                        end else begin
                            next_state = st_idle;
                        end
                    end
                end
                default: begin
                    next_state = st_idle;
                end
            endcase
        end
    end

    // registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= st_idle;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rx_sh <= 8'h00;
            tx_sh <= 8'hFF;
            bit_cnt <= 4'h0;
            phase <= 3'h0;
            is_read <= 1'b0;
            is_gc <= 1'b0;
            acked <= 1'b0;
            rd_lo <= 1'b0;
            pointer <= 8'h00;
            msb_buf <= 8'h00;
            rd_word <= 16'h0000;
            operating_configuration <= `CFG_RESET;
            lower_threshold <= `LOWER_RESET;
            upper_threshold <= `UPPER_RESET;
            cfg_write <= 1'b0;
            gc_reset <= 1'b0;
        end else begin
            state <= next_state;
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            bit_cnt <= next_bit_cnt;
            phase <= next_phase;
            is_read <= next_is_read;
            is_gc <= next_is_gc;
            acked <= next_acked;
            rd_lo <= next_rd_lo;
            pointer <= next_pointer;
            msb_buf <= next_msb_buf;
            rd_word <= next_rd_word;
            operating_configuration <= next_cfg;
            lower_threshold <= next_lower;
            upper_threshold <= next_upper;
            cfg_write <= next_cfg_write;
            gc_reset <= next_gc_reset;
        end
    end

    a_ptr_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(pointer) |-> ($past(state) == st_rx && $past(phase) == 3'h0) || gc_reset)
        else $error("pointer changed without write");
    a_ro_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == st_rx && fall && bit_cnt == `BYTE_BITS && phase == 3'h2 && !is_gc && !start_cond
        && !stop_cond && (pointer == `ADDR_RESULT || pointer >= `ADDR_MAKER)
        |=> $stable(operating_configuration) && $stable(lower_threshold) && $stable(upper_threshold))
        else $error("read-only write changed state");
    a_cfg_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg_write |-> operating_configuration == ($past(write_word) & `CFG_WR_MASK))
        else $error("config write value wrong");
    a_msb_first: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == st_ack && fall && is_read && !start_cond && !stop_cond
        |=> state == st_tx && tx_sh == rd_word[15:8] && rd_lo) else $error("high byte not first");
    a_ack_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == st_rx && !is_gc && fall && bit_cnt == `BYTE_BITS && !start_cond && !stop_cond
        |=> sda_oe && !sda_out) else $error("data byte not acknowledged");
    a_id_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == st_ack && fall && is_read && pointer == `ADDR_PART && !start_cond && !stop_cond
        |=> rd_word == `PART_ID) else $error("identity read wrong");
    a_gc_defaults: assert property (@(posedge core_clk) disable iff (sys_rst)
        gc_reset |-> operating_configuration == `CFG_RESET ##1 conversion_result == '0)
        else $error("general call defaults wrong");
    c_cfg_write: cover property (@(posedge core_clk) disable iff (sys_rst) cfg_write);
    c_read_lo: cover property (@(posedge core_clk) disable iff (sys_rst) state == st_tx && !rd_lo);
    c_gc_reset: cover property (@(posedge core_clk) disable iff (sys_rst) gc_reset);

endmodule : light_sensor_regs

// file: verif/i2c_host_model.sv
`timescale 1ns/1ps

// two-wire bus controller standing where the host processor sits
module i2c_host_model import light_sensor_pkg::*; (
    input wire logic core_clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    output bus_in_s bus_in
);
    logic scl = 1'b1; // bus clock, idle high
    logic sda_drv = 1'b1; // controller data, 1 means released
    // pull-up wins unless one party drives low; the device drives only while enabled
    assign bus_in = '{scl: scl, sda: sda_drv & (sda_oe ? sda_out : 1'b1)};

    // one scl phase lasts three core clocks
    task automatic half();
        repeat (3) @(negedge core_clk);
    endtask : half

    // start, also usable as repeated start
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask : start

    // stop leaves both lines high
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask : stop

    // one bit: data set while scl is low, line sampled while scl is high
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        r = bus_in.sda;
        scl = 1'b0;
    endtask : bit_io

    // eight bits most significant first, then the ninth acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ack_bit, a);
        ack = ~a;
    endtask : byte_io
endmodule : i2c_host_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "light_sensor_consts.svh"

module tb_top import light_sensor_pkg::*;;
    logic core_clk = 1'b0; // 50 MHz clock
    logic sys_rst = 1'b1; // held at start
    bus_in_s bus_in; // lines as seen by the device
    logic [6:0] target_addr = 7'h44; // strapped own address
    logic sda_out, sda_oe, cfg_write, gc_reset;
    logic conv_valid = 1'b0; // conversion done pulse
    conv_s conv_data = '0; // conversion outcome
    logic [3:0] status_bits = 4'h0; // read-only config flags
    logic [15:0] cfg_word, lower_threshold, upper_threshold;
    conv_s conversion_result;
    int mismatches = 0, tests_run = 0, cycles = 0, cfg_writes = 0, gc_pulses = 0;

    light_sensor_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_in(bus_in),
        .target_addr(target_addr), .sda_out(sda_out), .sda_oe(sda_oe), .conv_valid(conv_valid),
        .conv_data(conv_data), .status_bits(status_bits), .cfg_word(cfg_word), .cfg_write(cfg_write),
        .lower_threshold(lower_threshold), .upper_threshold(upper_threshold), .gc_reset(gc_reset),
        .conversion_result(conversion_result));
    i2c_host_model u_host (.core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out), .bus_in(bus_in));

    // free-running clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // counts, pulse tallies and the hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cfg_write === 1'b1) cfg_writes++;
        if (gc_reset === 1'b1) gc_pulses++;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // word comparison
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    // acknowledge comparison
    task automatic chk_ack(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s ack %b exp %b", $time, what, got, exp);
        end
    endtask : chk_ack

    // controller-sent byte with its expected acknowledge
    task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
        logic [7:0] r;
        logic a;
        u_host.byte_io(b, 1'b1, r, a);
        chk_ack(a, exp_ack, what);
    endtask : send

    // pointer then nb data bytes, most significant first
    task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int nb);
        u_host.start();
        send({target_addr, 1'b0}, 1'b1, "addr w");
        send(ptr, 1'b1, "pointer");
        for (int i = 0; i < nb; i++) send(d[15-8*i -: 8], 1'b1, "data");
        u_host.stop();
    endtask : wr

    // read one word at the kept pointer, nack after the low byte
    task automatic rd(output logic [15:0] v);
        logic a;
        u_host.start();
        send({target_addr, 1'b1}, 1'b1, "addr r");
        u_host.byte_io(8'hff, 1'b0, v[15:8], a);
        u_host.byte_io(8'hff, 1'b1, v[7:0], a);
        u_host.stop();
    endtask : rd

    task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] exp, input string what);
        logic [15:0] v;
        wr(ptr, 16'h0, 0);
        rd(v);
        chk_word(v, exp, what);
    endtask : rd_chk

    // one-cycle conversion pulse, then let the result settle
    task automatic push(input conv_s c);
        conv_data = c;
        conv_valid = 1'b1;
        @(negedge core_clk);
        conv_valid = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : push

    // expected result word for a range code, mask bit and engine outcome
    function automatic conv_s exp_res(input logic [3:0] code, input logic me, input conv_s c);
        if (code < `RANGE_AUTO) return '{exponent: me ? 4'h0 : code, mantissa: c.mantissa};
        if (c.exponent > `RANGE_TOP) return '{exponent: `RANGE_TOP, mantissa: `MANT_FULL};
        return c;
    endfunction : exp_res

    // main sequence
    initial begin
        logic [15:0] d, v, lo;
        conv_s c, e;
        void'($urandom(32'hf764));
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        // reset values through the bus, pointer starts at result
        rd(v);
        chk_word(v, 16'h0000, "result reset");
        rd_chk(`ADDR_CONFIG, `CFG_RESET, "cfg reset");
        rd_chk(`ADDR_LOWER, `LOWER_RESET, "lower reset");
        rd_chk(`ADDR_UPPER, `UPPER_RESET, "upper reset");
        rd_chk(`ADDR_MAKER, `MAKER_ID, "maker");
        rd_chk(`ADDR_PART, `PART_ID, "part");
        rd_chk(8'h10, 16'h0000, "unmapped");
        $display("test reset done");
        // thresholds and config, whole words only
        for (int k = 0; k < 4; k++) begin
            lo = 16'($urandom);
            wr(`ADDR_LOWER, lo, 2);
            rd_chk(`ADDR_LOWER, lo, "lower");
            d = 16'($urandom);
            wr(`ADDR_UPPER, d, 2);
            rd_chk(`ADDR_UPPER, d, "upper");
        end
        wr(`ADDR_LOWER, ~lo, 1);
        rd_chk(`ADDR_LOWER, lo, "lone msb");
        status_bits = 4'($urandom);
        d = 16'($urandom);
        wr(`ADDR_CONFIG, d, 2);
        chk_word(cfg_word, d & `CFG_WR_MASK, "cfg word");
        rd_chk(`ADDR_CONFIG, (d & `CFG_WR_MASK) | {7'h0, status_bits, 5'h0}, "cfg read");
        wr(`ADDR_MAKER, ~`MAKER_ID, 2);
        rd_chk(`ADDR_MAKER, `MAKER_ID, "maker ro");
        $display("test registers done");
        // every range code with and without the mask
        for (int k = 0; k < 32; k++) begin
            d = 16'($urandom);
            d[15:12] = k[3:0];
            d[`CFG_ME_BIT] = k[4];
            wr(`ADDR_CONFIG, d, 2);
            c = (k == 12) ? 16'hf123 : 16'($urandom);
            e = exp_res(k[3:0], k[4], c);
            push(c);
            chk_word(conversion_result, e, "result");
        end
        chk_word(16'(cfg_writes), 16'd33, "cfg pulses");
        rd_chk(`ADDR_RESULT, e, "result read");
        rd(v);
        chk_word(v, e, "repeat read");
        wr(`ADDR_RESULT, ~e, 2);
        rd(v);
        chk_word(v, e, "result ro");
        $display("test result done");
        // foreign address refused, then general-call reset
        u_host.start();
        send({target_addr ^ 7'h01, 1'b0}, 1'b0, "foreign");
        u_host.stop();
        u_host.start();
        send(8'h00, 1'b1, "gc addr");
        send(`GC_RESET_CMD, 1'b1, "gc cmd");
        u_host.stop();
        chk_word(lower_threshold, `LOWER_RESET, "gc lower");
        chk_word(upper_threshold, `UPPER_RESET, "gc upper");
        chk_word(cfg_word, `CFG_RESET & `CFG_WR_MASK, "gc cfg");
        chk_word(conversion_result, 16'h0000, "gc result");
        chk_word(16'(gc_pulses), 16'd1, "gc pulse");
        $display("test general call done");
        close_out();
    end
endmodule : tb_top
